// ### rtl/gppc_pkg.sv
// Constants for the eight-pin general-purpose port configuration block.
// Assumes a single processor clock and an asynchronous active-high system reset.
`default_nettype none

package gppc_pkg;

   localparam int         GPPC_WIDTH      = 8;
   localparam logic [7:0] GPPC_RESET_VAL  = 8'h00;
   localparam logic [7:0] GPPC_ANALOG_CAP = 8'hFF;

endpackage : gppc_pkg

`default_nettype wire

// ### rtl/gppc_port.sv
// Per-pin configuration of one general-purpose port.
// Assumes the core writes the three control registers through write strobes and
// that the pad ring resolves each pin from output, output enable and pull-up.
`default_nettype none

module gppc_port
   import gppc_pkg::*;
#(
   parameter int         WIDTH      = GPPC_WIDTH,
   parameter logic [7:0] ANALOG_CAP = GPPC_ANALOG_CAP
) (
   input  wire logic             CORE_CLK,     // Processor clock
   input  wire logic             SYS_RST,      // Asynchronous reset, active high
   input  wire logic [WIDTH-1:0] WR_DATA,      // Write data for all registers
   input  wire logic             WR_DIR,       // Write strobe, direction register
   input  wire logic             WR_OPT,       // Write strobe, option register
   input  wire logic             WR_LATCH,     // Write strobe, pin_data_latch
   input  wire logic             GLOBAL_INTERRUPT_ENABLE, // Global interrupt enable
   input  wire logic [WIDTH-1:0] PIN_IN,       // Pad input levels, asynchronous
   output logic      [WIDTH-1:0] DIR_Q,        // Direction register contents
   output logic      [WIDTH-1:0] OPT_Q,        // Option register contents
   output logic      [WIDTH-1:0] RD_DATA,      // Data register read value
   output logic      [WIDTH-1:0] PIN_OUT,      // Pad output level
   output logic      [WIDTH-1:0] PIN_OE_N,     // Pad output enable, low drives
   output logic      [WIDTH-1:0] PULLUP_EN,    // Pad pull-up enable
   output logic      [WIDTH-1:0] ANALOG_SEL,   // Route pin to analog converter
   output logic      [WIDTH-1:0] IRQ_PIN_LVL,  // Synchronised level of interrupt pins
   output logic                  EXT_IRQ       // External interrupt request, wakes core
);

   // The mode decode and the analog mask are built for at most eight pins.
   generate
      if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
         $error("gppc_port: WIDTH must be 1 to 8");
      end
   endgenerate

   logic [WIDTH-1:0] dir_r;
   logic [WIDTH-1:0] opt_r;
   logic [WIDTH-1:0] latch_r;
   logic [WIDTH-1:0] sync1_r;
   logic [WIDTH-1:0] sync2_r;
   logic [WIDTH-1:0] rd_nxt;
   logic [WIDTH-1:0] rd_r;
   logic             irq_r;
   wire  [WIDTH-1:0] int_mode;
   wire  [WIDTH-1:0] ana_mode;
   wire              irq_nxt;

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         dir_r   <= GPPC_RESET_VAL[WIDTH-1:0];
         opt_r   <= GPPC_RESET_VAL[WIDTH-1:0];
         latch_r <= GPPC_RESET_VAL[WIDTH-1:0];
      end else begin
         if (WR_DIR) begin
            dir_r <= WR_DATA;
         end
         if (WR_OPT) begin
            opt_r <= WR_DATA;
         end
         if (WR_LATCH) begin
            latch_r <= WR_DATA;
         end
      end
   end

   // ------------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sync1_r <= GPPC_RESET_VAL[WIDTH-1:0];
         sync2_r <= GPPC_RESET_VAL[WIDTH-1:0];
      end else begin
         sync1_r <= PIN_IN;
         sync2_r <= sync1_r;
      end
   end

   // ------------------------------------------------------------------
   // Per-pin mode decode
   // ------------------------------------------------------------------
   // The mode is a pure function of the three register bits, so low-power
   // states, which do not touch the registers, leave the pins unchanged.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_pin
         assign PULLUP_EN[i]  = ~dir_r[i] & ~latch_r[i];
         assign int_mode[i]   = ~dir_r[i] & opt_r[i] & ~latch_r[i];
         assign ana_mode[i]   = ~dir_r[i] & opt_r[i] & latch_r[i] & ANALOG_CAP[i];
         assign PIN_OE_N[i]   = ~(dir_r[i] & (opt_r[i] | ~latch_r[i]));
         assign PIN_OUT[i]    = latch_r[i];
         assign rd_nxt[i]     = dir_r[i] ? latch_r[i] : sync2_r[i];
      end
   endgenerate

   assign irq_nxt = GLOBAL_INTERRUPT_ENABLE & |(int_mode & ~sync2_r);

   // ------------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rd_r  <= GPPC_RESET_VAL[WIDTH-1:0];
         irq_r <= 1'b0;
      end else begin
         rd_r  <= rd_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign DIR_Q       = dir_r;
   assign OPT_Q       = opt_r;
   assign RD_DATA     = rd_r;
   assign ANALOG_SEL  = ana_mode;
   assign IRQ_PIN_LVL = int_mode & sync2_r;
   assign EXT_IRQ     = irq_r;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence s_pin_change;
      PIN_IN != $past(PIN_IN);
   endsequence

   // An enabled interrupt pin seen low after the synchroniser.
   sequence s_irq_cause;
      GLOBAL_INTERRUPT_ENABLE && ((int_mode & ~sync2_r) != '0);
   endsequence

   rst_clear_a: assert property (@(posedge CORE_CLK) $fell(SYS_RST) |->
      (dir_r == '0 && opt_r == '0 && latch_r == '0 && PULLUP_EN == '1))
      else $error("registers not cleared by reset");

   pull_mode_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      ((~dir_r & ~opt_r & ~latch_r) & (~PULLUP_EN | int_mode | ~PIN_OE_N)) == '0)
      else $error("pull-up input mode wrong");

   int_pull_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      ((~dir_r & opt_r & ~latch_r) & ~(PULLUP_EN & int_mode & PIN_OE_N)) == '0)
      else $error("interrupt input mode wrong");

   nopull_mode_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      ((~dir_r & ~opt_r & latch_r) & (PULLUP_EN | ANALOG_SEL)) == '0)
      else $error("plain input has pull-up or analog");

   analog_route_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      ((ANALOG_SEL & (dir_r | ~opt_r | ~latch_r)) == '0))
      else $error("analog routed outside analog mode");

   output_drive_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      ((dir_r & ~opt_r & ~latch_r) & (PIN_OE_N | PIN_OUT)) == '0)
      else $error("open-drain low not driven");

   drain_release_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      ((dir_r & ~opt_r & latch_r) & ~PIN_OE_N) == '0)
      else $error("open-drain high not released");

   push_pull_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      ((dir_r & opt_r) & (PIN_OE_N | (PIN_OUT ^ latch_r))) == '0)
      else $error("push-pull output wrong");

   input_release_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      ((~dir_r & ~PIN_OE_N) == '0) && ((dir_r & (PULLUP_EN | ANALOG_SEL)) == '0))
      else $error("input driven or output pulled");

   irq_raise_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      s_irq_cause |=> EXT_IRQ)
      else $error("interrupt request missing");

   cfg_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      !WR_DIR && !WR_OPT |=> $stable(dir_r) && $stable(opt_r))
      else $error("configuration changed without write");

   read_path_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      ##1 RD_DATA == (($past(dir_r) & $past(latch_r)) | (~$past(dir_r) & $past(sync1_r, 2))))
      else $error("data read value wrong");

   sync_delay_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      s_pin_change |-> ##2 sync2_r == $past(PIN_IN, 2))
      else $error("synchroniser delay wrong");

   irq_gate_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      EXT_IRQ |-> $past(GLOBAL_INTERRUPT_ENABLE) && $past(int_mode) != '0)
      else $error("interrupt without enable or interrupt pin");

   latch_cfg_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      WR_LATCH |=> latch_r == $past(WR_DATA))
      else $error("latch write lost");

endmodule : gppc_port

`default_nettype wire

// ### sim/gppc_pad_model.sv
// Pad model for one eight-pin port.
// Assumes the bench drives the outside of each pin through ext_val and ext_en.
`default_nettype none

module gppc_pad_model (
   input  wire logic       clk,     // Processor clock
   input  wire logic [7:0] pin_out, // Level from the port
   input  wire logic [7:0] oe_n,    // Low drives the pin
   input  wire logic [7:0] pu_en,   // Pull-up enable
   input  wire logic [7:0] ext_val, // Level from outside
   input  wire logic [7:0] ext_en,  // Outside drives the pin
   output logic      [7:0] lvl      // Resolved pin level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] flt_r = 8'h5A;
   // A pin that nobody holds reads a pattern that changes every cycle.
   always_ff @(posedge clk) flt_r <= ~flt_r;
   always_comb begin
      for (int i = 0; i < 8; i++)
         lvl[i] = !oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pu_en[i] ? 1'h1 : flt_r[i];
   end
endmodule // gppc_pad_model

`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the port configuration block.
// Assumes the pad model resolves the pins while the bench drives them from outside.
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] dir, opt, lat, ext;
      logic       gie;
      logic [7:0] pu, oen, an;
   } gppc_row_t;
   localparam gppc_row_t ROWS [4] = '{
      '{8'h00, 8'h00, 8'h00, 8'h00, 1'h1, 8'hFF, 8'hFF, 8'h00},
      '{8'hF0, 8'hCC, 8'hAA, 8'h00, 1'h1, 8'h05, 8'h2F, 8'h08},
      '{8'h0F, 8'h33, 8'h55, 8'hFF, 1'h1, 8'hA0, 8'hF4, 8'h10},
      '{8'h0F, 8'h33, 8'h55, 8'h00, 1'h0, 8'hA0, 8'hF4, 8'h10}};
   logic       clk = 1'h0, rst = 1'h1, wdir = 1'h0, wopt = 1'h0, wlat = 1'h0, gie = 1'h0;
   logic [7:0] wd = 8'h00, xv = 8'h00, xe = 8'h00, pin, dir_q, opt_q, rd, pout, oe_n, pu;
   logic [7:0] an, irql, im;
   logic       irq;
   int         miscompares = 0, n_compared = 0, cyc = 0;
   gppc_row_t  r;
   gppc_port gppc_port_i (.CORE_CLK(clk), .SYS_RST(rst), .WR_DATA(wd), .WR_DIR(wdir),
      .WR_OPT(wopt), .WR_LATCH(wlat), .GLOBAL_INTERRUPT_ENABLE(gie), .PIN_IN(pin),
      .DIR_Q(dir_q), .OPT_Q(opt_q), .RD_DATA(rd), .PIN_OUT(pout), .PIN_OE_N(oe_n),
      .PULLUP_EN(pu), .ANALOG_SEL(an), .IRQ_PIN_LVL(irql), .EXT_IRQ(irq));
   gppc_pad_model gppc_pad_model_i (.clk(clk), .pin_out(pout), .oe_n(oe_n), .pu_en(pu),
      .ext_val(xv), .ext_en(xe), .lvl(pin));
   always #4 clk = ~clk;
   task automatic test_done();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 500) begin
         miscompares++;
         test_done();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Latch first and direction last keeps every pin on a safe path between modes.
   task automatic put(input logic [2:0] s, input logic [7:0] d);
      {wdir, wopt, wlat} = s;
      wd = d;
      step(1);
   endtask
   task automatic chk_rst();
      chk(dir_q | opt_q | rd | pout | an, 8'h00);
      chk(pu & oe_n, 8'hFF);
      chk({7'h00, irq}, 8'h00);
   endtask
   initial begin
      step(20);
      chk_rst();
      rst = 1'h0;
      foreach (ROWS[k]) begin
         r = ROWS[k];
         put(3'h1, r.lat);
         put(3'h2, r.opt);
         put(3'h4, r.dir);
         {wdir, wopt, wlat} = 3'h0;
         gie = r.gie;
         xv = r.ext;
         xe = ~r.dir;
         step(5);
         im = ~r.dir & r.opt & ~r.lat;
         chk(dir_q, r.dir);
         chk(opt_q, r.opt);
         chk(pu, r.pu);
         chk(oe_n, r.oen);
         chk(an, r.an);
         chk(pout & r.dir, r.lat & r.dir);
         chk(rd, (r.lat & r.dir) | (r.ext & ~r.dir));
         chk(irql, r.ext & im);
         chk({7'h00, irq}, {7'h00, r.gie & |(im & ~r.ext)});
      end
      gie = 1'h1;
      xv = 8'hFF;
      step(4);
      xv = 8'h00;
      step(2);
      chk(rd, 8'hF5);
      chk({7'h00, irq}, 8'h00);
      step(1);
      chk(rd, 8'h05);
      chk({7'h00, irq}, 8'h01);
      chk(rd & 8'h0F, 8'h05);
      rst = 1'h1;
      xe = 8'h00;
      step(2);
      chk_rst();
      rst = 1'h0;
      step(2);
      chk_rst();
      step(2);
      chk(rd, 8'hFF);
      test_done();
   end
endmodule // tb

`default_nettype wire
